// File: design/cpp_pad_port.sv
// configurable pad port with fast shut-down trigger and axi4-lite registers
// assumes pad_in is the pad level, pad_out/pad_oe drive a push-pull buffer
// and pad_pd enables the weak pull-down of each pad
`timescale 1ns/1ns
`include "cpp_regs.svh"
module cpp_pad_port #(
  parameter int N = 10,
  parameter int ADDR_W = 8,
  parameter logic [15:0] ALT_MASK = 16'h0001
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [N-1:0] pad_in,
  output logic [N-1:0] pad_out,
  output logic [N-1:0] pad_oe,
  output logic [N-1:0] pad_pd,
  input wire logic [N-1:0] alt_out,
  input wire logic [N-1:0] alt_oe,
  input wire logic flush_ack,
  output logic flush_req,
  output logic power_off,
  output logic irq
);

  // ------------------------------------------------------------
  // parameter checks
  // ------------------------------------------------------------
  if (N < 1 || N > 16) begin : g_bad_n
    $error("pad count must be 1 to 16");
  end
  if (ADDR_W < 6 || ADDR_W > 8) begin : g_bad_aw
    $error("address width must be 6 to 8");
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [N-1:0] dir;
    logic [N-1:0] alt;
    logic [N-1:0] outv;
    logic [N-1:0] pull;
    logic [N-1:0] prev;
    logic [3:0] sel;
    logic hw_en;
    logic sw_go;
    logic hw_go;
    logic off_prev;
    logic [2:0] irq_st;
    logic [2:0] irq_mk;
    logic aw_ok;
    logic [ADDR_W-1:0] awa;
    logic w_ok;
    logic [31:0] wd;
    logic [3:0] ws;
    logic awrdy;
    logic wrdy;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [N-1:0] pout;
    logic [N-1:0] poe;
    logic [N-1:0] ppd;
    logic irq;
  } cpp_port_st_type;

  cpp_port_st_type st_q;
  cpp_port_st_type st_d;

  logic [N-1:0] pad_sync;
  logic seq_busy;
  logic seq_flush;
  logic seq_off;

  localparam logic [N-1:0] ALT_OK = ALT_MASK[N-1:0];

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] b;
    b = 8'(a);
    is_mapped = (b[1:0] == 2'b00) && (b <= `CPP_OFF_IRQ_MK);
  endfunction

  function automatic logic is_writable(input logic [ADDR_W-1:0] a);
    logic [7:0] b;
    b = 8'(a);
    is_writable = is_mapped(a) && (b != `CPP_OFF_IN);
  endfunction

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = strb_mask(s);
    merge = (old & ~m) | (nw & m);
  endfunction

  // ------------------------------------------------------------
  // submodules
  // ------------------------------------------------------------
  cpp_sync #(
    .W(N)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .din(pad_in),
    .dout(pad_sync)
  );

  cpp_fsd_seq u_seq (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(st_q.sw_go | st_q.hw_go),
    .flush_ack(flush_ack),
    .busy(seq_busy),
    .flush_req(seq_flush),
    .power_off(seq_off)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [7:0] wa;
    logic [7:0] ra;
    logic [31:0] rv;
    logic [31:0] wv;
    logic do_wr;
    logic sel_ok;
    logic [2:0] ev;
    logic [2:0] clr;
    wa = 8'(st_q.awa);
    ra = 8'(s_axi_araddr);
    rv = 32'h0;
    wv = 32'h0;
    do_wr = 1'b0;
    sel_ok = 1'b0;
    ev = 3'h0;
    clr = 3'h0;
    st_d = st_q;
    st_d.sw_go = 1'b0;

    // write channel capture, address and data in either order
    if (s_axi_awvalid && st_q.awrdy) begin
      st_d.aw_ok = 1'b1;
      st_d.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_q.wrdy) begin
      st_d.w_ok = 1'b1;
      st_d.wd = s_axi_wdata;
      st_d.ws = s_axi_wstrb;
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (st_q.aw_ok && st_q.w_ok && !st_q.bvalid) begin
      do_wr = is_writable(st_q.awa);
      st_d.aw_ok = 1'b0;
      st_d.w_ok = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = do_wr ? cpp_pkg::CPP_RESP_OKAY : cpp_pkg::CPP_RESP_SLVERR;
    end

    // register writes
    if (do_wr) begin
      unique case (wa)
        `CPP_OFF_DIR: begin
          wv = merge(32'(st_q.dir), st_q.wd, st_q.ws);
          st_d.dir = wv[N-1:0];
        end
        `CPP_OFF_ALT: begin
          wv = merge(32'(st_q.alt), st_q.wd, st_q.ws);
          st_d.alt = wv[N-1:0] & ALT_OK;
        end
        `CPP_OFF_OUT: begin
          wv = merge(32'(st_q.outv), st_q.wd, st_q.ws);
          st_d.outv = wv[N-1:0];
        end
        `CPP_OFF_PULL: begin
          wv = merge(32'(st_q.pull), st_q.wd, st_q.ws);
          st_d.pull = wv[N-1:0];
        end
        `CPP_OFF_SCFG: begin
          if (st_q.ws[0]) begin
            st_d.sel = st_q.wd[`CPP_SCFG_SEL_LSB +: `CPP_SCFG_SEL_W];
            st_d.hw_en = st_q.wd[`CPP_SCFG_HWEN_BIT];
          end
        end
        `CPP_OFF_SCTL: begin
          st_d.sw_go = st_q.ws[0] & st_q.wd[`CPP_SCTL_GO_BIT];
        end
        `CPP_OFF_IRQ_ST: begin
          if (st_q.ws[0]) begin
            clr = st_q.wd[2:0];
          end
        end
        `CPP_OFF_IRQ_MK: begin
          if (st_q.ws[0]) begin
            st_d.irq_mk = st_q.wd[2:0];
          end
        end
        default: begin
          wv = 32'h0;
        end
      endcase
    end

    // read channel
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_q.arrdy) begin
      unique case (ra)
        `CPP_OFF_DIR: rv = 32'(st_q.dir);
        `CPP_OFF_ALT: rv = 32'(st_q.alt);
        `CPP_OFF_OUT: rv = 32'(st_q.outv);
        `CPP_OFF_IN: rv = 32'(pad_sync & ~st_q.dir & ~st_q.alt);
        `CPP_OFF_PULL: rv = 32'(st_q.pull);
        `CPP_OFF_SCFG: rv = 32'({st_q.hw_en, st_q.sel});
        `CPP_OFF_SCTL: rv = 32'({seq_off, seq_flush, seq_busy});
        `CPP_OFF_IRQ_ST: rv = 32'(st_q.irq_st);
        `CPP_OFF_IRQ_MK: rv = 32'(st_q.irq_mk);
        default: rv = 32'h0;
      endcase
      st_d.rvalid = 1'b1;
      st_d.rdata = rv;
      st_d.rresp = is_mapped(s_axi_araddr) ? cpp_pkg::CPP_RESP_OKAY : cpp_pkg::CPP_RESP_SLVERR;
    end

    // shut-down trigger from the selected pad
    st_d.prev = pad_sync;
    sel_ok = (32'(st_q.sel) < N);
    st_d.hw_go = 1'b0;
    if (st_q.hw_en && sel_ok) begin
      st_d.hw_go = st_q.prev[st_q.sel] & ~pad_sync[st_q.sel];
    end

    // interrupt events; a set in the clearing cycle wins
    st_d.off_prev = seq_off;
    ev[`CPP_IRQ_HW_BIT] = st_q.hw_go;
    ev[`CPP_IRQ_SW_BIT] = st_q.sw_go;
    ev[`CPP_IRQ_OFF_BIT] = seq_off & ~st_q.off_prev;
    st_d.irq_st = (st_q.irq_st & ~clr) | ev;
    st_d.irq = |(st_d.irq_st & st_d.irq_mk);

    // ready flags registered from the next state
    st_d.awrdy = !st_d.aw_ok && !st_d.bvalid;
    st_d.wrdy = !st_d.w_ok && !st_d.bvalid;
    st_d.arrdy = !st_d.rvalid;

    // pad drive
    for (int i = 0; i < N; i++) begin
      if (st_d.alt[i]) begin
        st_d.pout[i] = alt_out[i];
        st_d.poe[i] = alt_oe[i];
      end else if (st_d.dir[i]) begin
        st_d.pout[i] = st_d.outv[i];
        st_d.poe[i] = 1'b1;
      end else begin
        st_d.pout[i] = 1'b0;
        st_d.poe[i] = 1'b0;
      end
      st_d.ppd[i] = st_d.pull[i] & ~st_d.poe[i];
    end
    if (seq_off) begin
      // nothing is driven once power is cut
      st_d.poe = '0;
      st_d.pout = '0;
      st_d.ppd = '0;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= '0;
      st_q.dir <= {N{`CPP_DIR_RST}};
      st_q.alt <= {N{`CPP_ALT_RST}};
      st_q.outv <= {N{`CPP_OUT_RST}};
      st_q.pull <= {N{`CPP_PULL_RST}};
      st_q.ppd <= {N{`CPP_PULL_RST}};
      st_q.sel <= `CPP_SEL_RST;
      st_q.hw_en <= `CPP_HWEN_RST;
      st_q.irq_st <= `CPP_IRQ_RST;
      st_q.irq_mk <= `CPP_IRQ_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign s_axi_awready = st_q.awrdy;
  assign s_axi_wready = st_q.wrdy;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = st_q.arrdy;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;
  assign pad_out = st_q.pout;
  assign pad_oe = st_q.poe;
  assign pad_pd = st_q.ppd;
  assign flush_req = seq_flush;
  assign power_off = seq_off;
  assign irq = st_q.irq;

endmodule

// File: shared/cpp_regs.svh
// register map, field positions and reset values of the pad port
// assumes a 32-bit axi4-lite slave with byte addresses on 8 bits
//
// Notes on behaviour
// - input read returns present pad level (code reads 0 for output and alternate pads)
// - output pad: software writes or reads level
// - alternate pad driven by internal function only
// - reset: inputs with pull-down; pad one alternate (code resets alt to 0, so pad one comes up a plain input)
// - output pads drive both levels
// - any pad selectable as shut-down source
// - high-to-low edge on source starts shut-down
// - software command also starts shut-down
// - shut-down closes storage, then powers off quietly
`ifndef CPP_REGS_SVH
`define CPP_REGS_SVH

`define CPP_OFF_DIR 8'h00
`define CPP_OFF_ALT 8'h04
`define CPP_OFF_OUT 8'h08
`define CPP_OFF_IN 8'h0c
`define CPP_OFF_PULL 8'h10
`define CPP_OFF_SCFG 8'h14
`define CPP_OFF_SCTL 8'h18
`define CPP_OFF_IRQ_ST 8'h1c
`define CPP_OFF_IRQ_MK 8'h20

`define CPP_SCFG_SEL_LSB 0
`define CPP_SCFG_SEL_W 4
`define CPP_SCFG_HWEN_BIT 4
`define CPP_SCTL_GO_BIT 0
`define CPP_SCTL_BUSY_BIT 0
`define CPP_SCTL_FLUSH_BIT 1
`define CPP_SCTL_OFF_BIT 2

`define CPP_IRQ_HW_BIT 0
`define CPP_IRQ_SW_BIT 1
`define CPP_IRQ_OFF_BIT 2
`define CPP_IRQ_W 3

`define CPP_DIR_RST 1'b0
`define CPP_ALT_RST 1'b0
`define CPP_OUT_RST 1'b0
`define CPP_PULL_RST 1'b1
`define CPP_SEL_RST 4'h0
`define CPP_HWEN_RST 1'b0
`define CPP_IRQ_RST 3'h0

`endif

// File: shared/cpp_pkg.sv
// types shared by the pad port and its shut-down sequencer
// assumes the constants header is included by the modules
package cpp_pkg;

  typedef enum logic [2:0] {
    CPP_FSD_IDLE = 3'b001,
    CPP_FSD_FLUSH = 3'b010,
    CPP_FSD_OFF = 3'b100
  } cpp_fsd_state_type;

  typedef enum logic [1:0] {
    CPP_RESP_OKAY = 2'b00,
    CPP_RESP_SLVERR = 2'b10
  } cpp_resp_type;

endpackage

// File: design/cpp_sync.sv
// two-stage synchroniser for a vector of pad levels
// assumes pad levels may change at any time relative to clk_sys
`timescale 1ns/1ns
module cpp_sync #(
  parameter int W = 10
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } cpp_sync_st_type;

  cpp_sync_st_type st_q;
  cpp_sync_st_type st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.s2;

endmodule

// File: design/cpp_fsd_seq.sv
// fast shut-down sequencer: close storage, then cut power
// assumes the storage side holds flush_ack high once it is closed
`timescale 1ns/1ns
module cpp_fsd_seq (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start,
  input wire logic flush_ack,
  output logic busy,
  output logic flush_req,
  output logic power_off
);

  typedef struct packed {
    cpp_pkg::cpp_fsd_state_type state;
    logic busy;
    logic flush_req;
    logic power_off;
  } cpp_seq_st_type;

  cpp_seq_st_type st_q;
  cpp_seq_st_type st_d;

  always_comb begin
    st_d = st_q;
    unique case (st_q.state)
      cpp_pkg::CPP_FSD_IDLE: begin
        if (start) begin
          st_d.state = cpp_pkg::CPP_FSD_FLUSH;
        end
      end
      cpp_pkg::CPP_FSD_FLUSH: begin
        if (flush_ack) begin
          st_d.state = cpp_pkg::CPP_FSD_OFF;
        end
      end
      cpp_pkg::CPP_FSD_OFF: begin
        st_d.state = cpp_pkg::CPP_FSD_OFF;
      end
      default: begin
        st_d.state = cpp_pkg::CPP_FSD_IDLE;
      end
    endcase
    st_d.busy = (st_d.state != cpp_pkg::CPP_FSD_IDLE);
    st_d.flush_req = (st_d.state == cpp_pkg::CPP_FSD_FLUSH);
    st_d.power_off = (st_d.state == cpp_pkg::CPP_FSD_OFF);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q.state <= cpp_pkg::CPP_FSD_IDLE;
      st_q.busy <= 1'b0;
      st_q.flush_req <= 1'b0;
      st_q.power_off <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign busy = st_q.busy;
  assign flush_req = st_q.flush_req;
  assign power_off = st_q.power_off;

endmodule

// File: tb/cpp_pad_partner.sv
// far-side pad model: external 1.8 V logic on every pad
// assumes pad_in is fed back to the port under test
`timescale 1ns/1ns
module cpp_pad_partner #(
  parameter int N = 10
) (
  input wire logic clk_sys,
  input wire logic [N-1:0] pad_out,
  input wire logic [N-1:0] pad_oe,
  input wire logic [N-1:0] pad_pd,
  input wire logic [N-1:0] ext_en,
  input wire logic [N-1:0] ext_val,
  output logic [N-1:0] pad_in
);
  // a floating pad wanders so no stale level survives
  logic [N-1:0] flt_q = '0;
  always @(posedge clk_sys) flt_q <= ~flt_q;
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_pd[i]) pad_in[i] = 1'b0;
      else pad_in[i] = flt_q[i];
    end
  end
endmodule

// File: tb/cpp_pad_port_checker.sv
// assertions on bus answers, pad drive and shut-down outputs
// assumes it is bound into every pad port instance
`timescale 1ns/1ns
module cpp_pad_port_checker #(
  parameter int N = 10
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_arready,
  input wire logic [N-1:0] pad_oe,
  input wire logic [N-1:0] pad_pd,
  input wire logic flush_ack,
  input wire logic flush_req,
  input wire logic power_off
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_reset_pads: assert property ($fell(rst) |-> pad_oe == '0 && pad_pd == '1)
    else $error("pads not inputs with pull-down after reset");
  a_pull_excl: assert property ((pad_oe & pad_pd) == '0)
    else $error("pull-down on a driven pad");
  a_off_sticky: assert property (power_off |=> power_off)
    else $error("power-off dropped");
  a_off_quiet: assert property (power_off && $past(power_off) |-> pad_oe == '0 && pad_pd == '0 && !flush_req)
    else $error("pads or flush active in power-off");
  a_off_after_ack: assert property ($rose(power_off) |-> $past(flush_ack))
    else $error("power-off before storage closed");
  a_flush_hold: assert property (flush_req && !flush_ack |=> flush_req)
    else $error("flush request dropped early");
  a_wr_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  a_rd_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  a_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
endmodule
bind cpp_pad_port cpp_pad_port_checker #(.N(N)) u_cpp_pad_port_checker (
  .clk_sys(clk_sys), .rst(rst), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_arready(s_axi_arready),
  .pad_oe(pad_oe), .pad_pd(pad_pd), .flush_ack(flush_ack), .flush_req(flush_req), .power_off(power_off)
);

// File: tb/cpp_pad_port_bench.sv
// self-checking bench of the pad port against an integer model
// assumes package, design, partner and checker are compiled first
`timescale 1ns/1ns
module cpp_pad_port_bench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0, ack = 1'b0;
  logic [7:0] awa = '0, ara = '0;
  logic [31:0] wd = '0;
  logic [9:0] aout = '0, aoe = '0, een = '0, eval = '0;
  logic awr, wrd, bv, arr, rv, fr, po, irq, hit;
  logic [1:0] br, rr, rsp;
  logic [31:0] rdat, got;
  logic [9:0] pin, pout, poe, ppd;
  int err_count = 0, checks_done = 0, cyc = 0;
  int m_dir = 0, m_out = 0, m_alt = 0, m_pull = 'h3ff, k, sel;
  cpp_pad_port u_cpp_pad_port (
    .clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .pad_in(pin), .pad_out(pout), .pad_oe(poe), .pad_pd(ppd), .alt_out(aout), .alt_oe(aoe),
    .flush_ack(ack), .flush_req(fr), .power_off(po), .irq(irq)
  );
  cpp_pad_partner u_cpp_pad_partner (
    .clk_sys(clk_sys), .pad_out(pout), .pad_oe(poe), .pad_pd(ppd), .ext_en(een), .ext_val(eval),
    .pad_in(pin)
  );
  initial forever #20 clk_sys = ~clk_sys;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(negedge clk_sys);
      ta = awv & awr;
      tw = wv & wrd;
      tb = bv;
      rsp = br;
      @(posedge clk_sys);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (!tb);
    bry <= 1'b0;
    @(posedge clk_sys);
    chk({30'h0, rsp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr;
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(negedge clk_sys);
      ta = arv & arr;
      tr = rv;
      got = rdat;
      rsp = rr;
      @(posedge clk_sys);
      if (ta) arv <= 1'b0;
    end while (!tr);
    rry <= 1'b0;
    @(posedge clk_sys);
    chk(got, ed);
    chk({30'h0, rsp}, {30'h0, er});
  endtask
  task automatic pads();
    int e;
    e = (m_alt & int'(aoe)) | (m_dir & ~m_alt);
    @(negedge clk_sys);
    chk({22'h0, poe}, 32'(e));
    chk({22'h0, pout} & 32'(e), 32'(((m_alt & int'(aout)) | (m_out & ~m_alt)) & e));
    chk({22'h0, ppd}, 32'(m_pull & ~e & 'h3ff));
    @(posedge clk_sys);
  endtask
  task automatic irq_chk(input logic e);
    @(negedge clk_sys);
    chk({31'h0, irq}, {31'h0, e});
    @(posedge clk_sys);
  endtask
  task automatic wait_hi(input int which);
    hit = 1'b0;
    for (int i = 0; i < 12 && !hit; i++) begin
      @(negedge clk_sys);
      hit = (which == 0) ? fr : po;
    end
    @(posedge clk_sys);
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    void'($urandom(32'h5715f040));
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    for (k = 0; k < 9; k++) rd(8'(k * 4), (k == 4) ? 32'h3ff : 32'h0, 2'b00);
    rd(8'h24, 32'h0, 2'b10);
    wr(8'h0c, 32'h3ff, 2'b10);
    $display("reset test done");
    repeat (4) begin
      m_dir = int'($urandom % 1024);
      m_out = int'($urandom % 1024);
      wr(8'h00, 32'(m_dir), 2'b00);
      wr(8'h08, 32'(m_out), 2'b00);
      m_pull = int'($urandom % 1024);
      wr(8'h10, 32'(m_pull), 2'b00);
      een <= 10'(~m_dir);
      eval <= 10'($urandom);
      repeat (3) @(posedge clk_sys);
      pads();
      rd(8'h0c, 32'(eval & een), 2'b00);
      rd(8'h08, 32'(m_out), 2'b00);
    end
    $display("pad test done");
    wr(8'h04, 32'h3ff, 2'b00);
    m_alt = 1;
    rd(8'h04, 32'h1, 2'b00);
    for (k = 0; k < 2; k++) begin
      aoe <= 10'(k);
      aout <= 10'h3ff;
      // pad one's plain output level differs from the alternate drive
      m_out = m_out & 'h3fe;
      wr(8'h08, 32'(m_out), 2'b00);
      pads();
    end
    wr(8'h04, 32'h0, 2'b00);
    m_alt = 0;
    $display("alternate test done");
    m_dir = 0;
    wr(8'h00, 32'h0, 2'b00);
    een <= 10'h3ff;
    eval <= 10'h3ff;
    sel = 1 + int'($urandom % 9);
    wr(8'h14, 32'(16 + sel), 2'b00);
    wr(8'h20, 32'h7, 2'b00);
    eval[sel - 1] <= 1'b0;
    wait_hi(0);
    chk({31'h0, hit}, 32'h0);
    eval[sel] <= 1'b0;
    wait_hi(0);
    chk({31'h0, hit}, 32'h1);
    rd(8'h1c, 32'h1, 2'b00);
    rd(8'h18, 32'h3, 2'b00);
    irq_chk(1'b1);
    ack <= 1'b1;
    wait_hi(1);
    chk({31'h0, hit}, 32'h1);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({12'h0, poe, ppd}, 32'h0);
    @(posedge clk_sys);
    rd(8'h1c, 32'h5, 2'b00);
    $display("hardware shut-down test done");
    rst <= 1'b1;
    ack <= 1'b0;
    een <= 10'h0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    wr(8'h18, 32'h1, 2'b00);
    wait_hi(0);
    chk({31'h0, hit}, 32'h1);
    rd(8'h1c, 32'h2, 2'b00);
    irq_chk(1'b0);
    wr(8'h20, 32'h2, 2'b00);
    irq_chk(1'b1);
    wr(8'h1c, 32'h2, 2'b00);
    irq_chk(1'b0);
    rd(8'h1c, 32'h0, 2'b00);
    $display("software shut-down test done");
    finish_test();
  end
endmodule
